// File: wdc_watchdog_ctrl.sv
// watchdog control register, unlock sequence, bus slave and expiry reset
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wdc_watchdog_ctrl
    import wdc_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = WDC_BASE_CYCLES,
    parameter int unsigned CNT_W       = WDC_CNT_W
) (
    // system clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // bus slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // watchdog oscillator
    input  wire logic        wdt_clk,
    // safety fuse, high when programmed
    input  wire logic        safety_fuse,
    // results
    output logic             wdt_reset_pulse,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    wdc_aphase_t            dph_q;
    logic                   aphase;
    logic [7:0]             wd;
    logic                   ctrl_wr;
    logic                   kick_wr;
    logic                   stat_wr;
    logic                   mask_wr;
    logic                   wr_unlock;
    logic                   wr_on;
    logic [WDC_SEL_W-1:0]   wr_sel;
    logic                   arm;
    logic                   apply;
    logic                   refuse;
    logic                   on_q;
    logic [WDC_SEL_W-1:0]   sel_q;
    logic                   unlock_q;
    logic [2:0]             unlock_cnt_q;
    logic                   fuse_l2;
    logic                   on_eff;
    wdc_cfg_t               cfg_cur;
    wdc_cfg_t               cfg_xfer_q;
    logic                   cfg_tgl_q;
    logic                   cfg_ack;
    logic                   kick_tgl_q;
    logic                   expire_tgl;
    logic [1:0]             back_s;
    logic                   exp_seen_q;
    logic                   exp_evt;
    logic                   xfer_busy;
    logic [WDC_IRQ_W-1:0]   stat_q;
    logic [WDC_IRQ_W-1:0]   stat_set;
    logic [WDC_IRQ_W-1:0]   mask_q;
    logic [31:0]            rdata_d;

    // true when a data-phase write hits the given register
    function automatic logic hit(input wdc_aphase_t ph,
                                 input logic [7:0] off);
        hit = ph.valid && ph.write && (ph.addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // address phase capture; the slave never waits
    assign aphase = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= '0;
        end else if (hready) begin
            dph_q.valid <= aphase;
            dph_q.write <= hwrite;
            dph_q.addr  <= {haddr[7:2], 2'b00};
        end
    end

    // zero wait states, always an okay response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write decode; only the low byte of the control word matters
    assign wd        = hwdata[7:0];
    assign ctrl_wr   = hit(dph_q, WDC_CTRL_OFF);
    assign kick_wr   = hit(dph_q, WDC_KICK_OFF);
    assign stat_wr   = hit(dph_q, WDC_IRQ_STAT_OFF);
    assign mask_wr   = hit(dph_q, WDC_IRQ_MASK_OFF);
    assign wr_unlock = wd[WDC_UNLOCK_BIT];
    assign wr_on     = wd[WDC_ON_BIT];
    assign wr_sel    = wd[WDC_SEL_LSB +: WDC_SEL_W];

    // arming needs unlock and enable in one write
    assign arm   = ctrl_wr && wr_unlock && wr_on;
    // second step of the sequence: unlock armed, written back clear
    assign apply = ctrl_wr && unlock_q && !wr_unlock;
    // a disable attempt that will not take
    assign refuse = ctrl_wr && !wr_on && on_eff && (!apply || fuse_l2);

    ////////////////////////////////////////////////////////////////////////
    // fuse is a pin, so it is synchronised before use
    wdc_sync #(.W(1)) u_fuse_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (safety_fuse),
        .q     (fuse_l2)
    );

    // level two forces enable on and reads it as one
    // so no write sequence can stop the counter
    assign on_eff = on_q || fuse_l2;

    ////////////////////////////////////////////////////////////////////////
    // enable bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_q <= WDC_CTRL_RST[WDC_ON_BIT];
        end else if (ctrl_wr) begin
            if (wr_on) begin
                on_q <= 1'b1;
            // clearing only inside the unlock window
            end else if (apply) begin
                on_q <= 1'b0;
            end
        end
    end

    // timeout select guarded by the unlock window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= WDC_CTRL_RST[WDC_SEL_LSB +: WDC_SEL_W];
        end else if (apply) begin
            sel_q <= wr_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unlock window closes itself after four clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock_q     <= WDC_CTRL_RST[WDC_UNLOCK_BIT];
            unlock_cnt_q <= '0;
        end else if (arm) begin
            unlock_q     <= 1'b1;
            unlock_cnt_q <= WDC_UNLOCK_CYCLES;
        end else if (apply) begin
            // sequence used up, another change needs a fresh arm
            unlock_q     <= 1'b0;
            unlock_cnt_q <= '0;
        end else if (unlock_q) begin
            if (unlock_cnt_q == 3'h1) begin
                unlock_q <= 1'b0;
            end
            unlock_cnt_q <= unlock_cnt_q - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settings go over by toggle and acknowledge, one at a time
    assign cfg_cur   = '{on: on_eff, sel: sel_q};
    assign xfer_busy = (back_s[1] != cfg_tgl_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_xfer_q <= '0;
            cfg_tgl_q  <= 1'b0;
        end else if (!xfer_busy && (cfg_cur != cfg_xfer_q)) begin
            cfg_xfer_q <= cfg_cur;
            cfg_tgl_q  <= ~cfg_tgl_q;
        end
    end

    // kick write flips a toggle; two kicks inside one
    // oscillator period may cancel out, and then the count is not restarted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kick_tgl_q <= 1'b0;
        end else if (kick_wr) begin
            kick_tgl_q <= ~kick_tgl_q;
        end
    end

    wdc_tick_counter #(
        .BASE_CYCLES (BASE_CYCLES),
        .CNT_W       (CNT_W)
    ) u_counter (
        .wdt_clk    (wdt_clk),
        .hresetn    (hresetn),
        .cfg_xfer   (cfg_xfer_q),
        .cfg_tgl    (cfg_tgl_q),
        .cfg_ack    (cfg_ack),
        .kick_tgl   (kick_tgl_q),
        .expire_tgl (expire_tgl)
    );

    // acknowledge and expiry toggles come back synchronised
    wdc_sync #(.W(2)) u_back_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({cfg_ack, expire_tgl}),
        .q     (back_s)
    );

    assign exp_evt = back_s[0] ^ exp_seen_q;

    ////////////////////////////////////////////////////////////////////////
    // expiry becomes a single-cycle reset pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exp_seen_q      <= 1'b0;
            wdt_reset_pulse <= 1'b0;
        end else begin
            exp_seen_q <= back_s[0];
            // a late expiry after disable is dropped
            wdt_reset_pulse <= exp_evt && on_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky events; a new event wins over a clear in the same cycle
    assign stat_set[WDC_IRQ_EXPIRE]  = exp_evt && on_eff;
    assign stat_set[WDC_IRQ_REFUSED] = refuse;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= WDC_IRQ_RST;
        end else if (stat_wr) begin
            stat_q <= (stat_q & ~hwdata[WDC_IRQ_W-1:0]) | stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= WDC_IRQ_RST;
        end else if (mask_wr) begin
            mask_q <= hwdata[WDC_IRQ_W-1:0];
        end
    end

    // level interrupt, registered so it lags status by one clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, sampled in the address phase; unmapped reads give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (haddr[7:2] == WDC_CTRL_OFF[7:2]) begin
            rdata_d[WDC_UNLOCK_BIT] = unlock_q;
            rdata_d[WDC_ON_BIT]     = on_eff;
            rdata_d[WDC_SEL_LSB +: WDC_SEL_W] = sel_q;
        end else if (haddr[7:2] == WDC_IRQ_STAT_OFF[7:2]) begin
            rdata_d[WDC_IRQ_W-1:0] = stat_q;
        end else if (haddr[7:2] == WDC_IRQ_MASK_OFF[7:2]) begin
            rdata_d[WDC_IRQ_W-1:0] = mask_q;
        end else if (haddr[7:2] == WDC_STATUS_OFF[7:2]) begin
            rdata_d[3:0] = {xfer_busy, unlock_q, fuse_l2, on_eff};
        end
        if (haddr[31:8] != 24'h00_0000) begin
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (aphase && !hwrite) begin
            hrdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the system clock side
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence arm_s;
        arm;
    endsequence

    sequence quiet4_s;
        (!ctrl_wr) [*4];
    endsequence

    enable_set_a: assert property (
        (ctrl_wr && wr_on) |=> on_q && rdata_d[WDC_ON_BIT] == 1'b1
            || haddr[7:2] != WDC_CTRL_OFF[7:2] || haddr[31:8] != 0)
        else $error("enable write did not turn watchdog on");

    disable_guard_a: assert property (
        (ctrl_wr && !wr_on && !unlock_q && on_q) |=> on_q)
        else $error("enable cleared without unlock");

    unlock_close_a: assert property (
        arm_s ##1 quiet4_s |=> !unlock_q)
        else $error("unlock bit not cleared after four clocks");

    unlock_open_a: assert property (
        arm_s |=> unlock_q && unlock_cnt_q == WDC_UNLOCK_CYCLES)
        else $error("unlock window not opened");

    select_lock_a: assert property (
        (ctrl_wr && !unlock_q) |=> $stable(sel_q))
        else $error("timeout changed without unlock");

    // settled transfer must carry enable on while the fuse holds it
    level2_on_a: assert property (
        (fuse_l2 && !xfer_busy) |=> cfg_xfer_q.on)
        else $error("level two watchdog not running");

    pulse_enabled_a: assert property (
        wdt_reset_pulse |-> $past(on_eff) && $past(exp_evt))
        else $error("reset pulse without enabled expiry");

    pulse_single_a: assert property (
        wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("reset pulse longer than one clock");

    level1_start_a: assert property (
        (!fuse_l2 && !$past(on_q) && !$past(ctrl_wr && wr_on)) |-> !on_eff)
        else $error("level one watchdog on without write");

endmodule
`default_nettype wire

// File: wdc_pkg.sv
// package of shared constants and types for the watchdog control block
package wdc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the bus
    localparam logic [7:0] WDC_CTRL_OFF     = 8'h00;
    localparam logic [7:0] WDC_KICK_OFF     = 8'h04;
    localparam logic [7:0] WDC_IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0] WDC_IRQ_MASK_OFF = 8'h0C;
    localparam logic [7:0] WDC_STATUS_OFF   = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int unsigned WDC_UNLOCK_BIT = 4;
    localparam int unsigned WDC_ON_BIT     = 3;
    localparam int unsigned WDC_SEL_LSB    = 0;
    localparam int unsigned WDC_SEL_W      = 3;
    localparam logic [7:0]  WDC_CTRL_RST   = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask bits
    localparam int unsigned WDC_IRQ_W       = 2;
    localparam int unsigned WDC_IRQ_EXPIRE  = 0;
    localparam int unsigned WDC_IRQ_REFUSED = 1;
    localparam logic [1:0]  WDC_IRQ_RST     = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // timing: unlock window in system clocks, timeout base in osc cycles
    localparam logic [2:0]  WDC_UNLOCK_CYCLES = 3'h4;
    localparam int unsigned WDC_BASE_CYCLES   = 16384;
    localparam int unsigned WDC_SEL_SPAN      = 128;
    localparam int unsigned WDC_CNT_W         = 21;

    ////////////////////////////////////////////////////////////////////////
    // settings carried into the oscillator domain
    typedef struct packed {
        logic       on;
        logic [2:0] sel;
    } wdc_cfg_t;

    // captured bus address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } wdc_aphase_t;

endpackage

// File: wdc_sync.sv
// two flip-flop level synchroniser, a vector of independent bits
`timescale 1ns/1ps
`default_nettype none
module wdc_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset of the receiving domain
    input  wire logic         clk,
    input  wire logic         rst_n,
    // level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule
`default_nettype wire

// File: wdc_tick_counter.sv
// watchdog counter running on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module wdc_tick_counter
    import wdc_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = WDC_BASE_CYCLES,
    parameter int unsigned CNT_W       = WDC_CNT_W
) (
    // oscillator clock and the system reset
    input  wire logic     wdt_clk,
    input  wire logic     hresetn,
    // settings handshake from the system clock side
    input  wire wdc_cfg_t cfg_xfer,
    input  wire logic     cfg_tgl,
    output logic          cfg_ack,
    // kick toggle in, expiry toggle out
    input  wire logic     kick_tgl,
    output logic          expire_tgl
);

    // largest timeout must fit the counter
    if (BASE_CYCLES * WDC_SEL_SPAN > (64'd1 << CNT_W) || BASE_CYCLES < 2)
    begin : g_bad_width
        $error("wdc_tick_counter: counter too narrow for timeout");
    end

    logic             rst_meta_q;
    logic             rst_q;
    logic [1:0]       tgl_s;
    logic             kick_seen_q;
    wdc_cfg_t         cfg_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W:0]   last;
    logic             kick;

    ////////////////////////////////////////////////////////////////////////
    // reset enters asynchronously, leaves on an oscillator edge
    always_ff @(posedge wdt_clk or negedge hresetn) begin
        if (!hresetn) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    wdc_sync #(.W(2)) u_sync (
        .clk   (wdt_clk),
        .rst_n (rst_q),
        .d     ({cfg_tgl, kick_tgl}),
        .q     (tgl_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // settings held stable until acknowledged
    always_ff @(posedge wdt_clk or negedge rst_q) begin
        if (!rst_q) begin
            cfg_q   <= '0;
            cfg_ack <= 1'b0;
        end else if (tgl_s[1] != cfg_ack) begin
            cfg_q   <= cfg_xfer;
            cfg_ack <= tgl_s[1];
        end
    end

    // final count is one less than base shifted by select code
    assign last = ((CNT_W+1)'(BASE_CYCLES) << cfg_q.sel) - 1'b1;
    assign kick = tgl_s[0] ^ kick_seen_q;

    ////////////////////////////////////////////////////////////////////////
    // restart on kick, disable or reset
    always_ff @(posedge wdt_clk or negedge rst_q) begin
        if (!rst_q) begin
            cnt_q       <= '0;
            kick_seen_q <= 1'b0;
            expire_tgl  <= 1'b0;
        end else begin
            kick_seen_q <= tgl_s[0];
            if (!cfg_q.on || kick) begin
                cnt_q <= '0;
            end else if ({1'b0, cnt_q} == last) begin
                cnt_q      <= '0;
                expire_tgl <= ~expire_tgl;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge wdt_clk); endclocking
    default disable iff (!rst_q);

    expire_at_limit_a: assert property (
        $changed(expire_tgl) |-> $past(cfg_q.on)
            && ({1'b0, $past(cnt_q)} == $past(last)))
        else $error("expiry not at selected count");

    kick_restart_a: assert property (
        (kick || !cfg_q.on) |=> cnt_q == '0)
        else $error("counter not restarted");

endmodule
`default_nettype wire

// File: wdc_watchdog_ctrl_tb_top.sv
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdc_watchdog_ctrl_tb_top
    import wdc_pkg::*;
#(
    parameter int unsigned BASE = 16
);
    logic        hclk, hresetn, hsel, hwrite, wdt_clk, safety_fuse;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, wdt_reset_pulse, irq;
    logic        pulse_q = 1'b0;
    int          err_count = 0;
    int          num_checks = 0;
    int          pulse_cnt = 0;

    // system clock and an unrelated oscillator clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        wdt_clk = 1'b0;
        forever #18.5 wdt_clk = ~wdt_clk;
    end

    // short base count keeps the longest select code affordable
    wdc_watchdog_ctrl #(.BASE_CYCLES(BASE), .CNT_W(WDC_CNT_W)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .wdt_clk(wdt_clk), .safety_fuse(safety_fuse),
        .wdt_reset_pulse(wdt_reset_pulse), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // verdict, compares and bus cycles
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // one single word transfer, no cycle count assumed
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk_val(r, e);
        chk_val({30'h0, hresp, hreadyout}, 32'h1);
    endtask
    task automatic wait_pulse(input int maxc, output int n);
        n = 0;
        while (wdt_reset_pulse !== 1'b1 && n < maxc) begin
            @(posedge hclk);
            n++;
        end
    endtask

    // count expiry pulses; a pulse must drop after one cycle
    always @(posedge hclk) begin
        if (wdt_reset_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
        if (pulse_q === 1'b1) chk_val({31'h0, wdt_reset_pulse}, 32'h0); // one cycle wide
        pulse_q <= wdt_reset_pulse;
    end

    // a hang ends the run as a failure
    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        report_and_stop;
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int n;
        int lo;
        int p0;
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; safety_fuse = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(WDC_CTRL_OFF, {24'h0, WDC_CTRL_RST}); // starts off
        rchk(WDC_IRQ_MASK_OFF, 32'h0);
        rchk(WDC_STATUS_OFF, 32'h0);
        rchk(8'h20, 32'h0);
        repeat (150) @(posedge hclk);
        chk_val(pulse_cnt, 32'h0); // no expiry while off
        wr(WDC_CTRL_OFF, 32'h08); // plain enable
        rchk(WDC_CTRL_OFF, 32'h08); // enable set
        wr(WDC_CTRL_OFF, 32'h18); // arm sequence
        wr(WDC_CTRL_OFF, 32'h0F);
        wr(WDC_KICK_OFF, 32'h1);
        rchk(WDC_CTRL_OFF, 32'h0F); // select in window
        // clear and select change outside the window are refused
        wr(WDC_CTRL_OFF, 32'h00);
        wr(WDC_CTRL_OFF, 32'h09);
        rchk(WDC_CTRL_OFF, 32'h0F); // both ignored
        rchk(WDC_IRQ_STAT_OFF, 32'h2); // refusal flagged
        wr(WDC_IRQ_STAT_OFF, 32'h3);
        rchk(WDC_IRQ_STAT_OFF, 32'h0);
        wr(WDC_CTRL_OFF, 32'h1F);
        rchk(WDC_CTRL_OFF, 32'h1F); // window open
        repeat (4) @(posedge hclk);
        rchk(WDC_CTRL_OFF, 32'h0F); // window closed
        wr(WDC_CTRL_OFF, 32'h18);
        wr(WDC_CTRL_OFF, 32'h00); // disable step
        rchk(WDC_CTRL_OFF, 32'h00); // disabled
        p0 = pulse_cnt;
        repeat (300) @(posedge hclk);
        chk_val(pulse_cnt, p0); // no expiry while off
        // regular kicks keep the shortest count from expiring
        wr(WDC_IRQ_MASK_OFF, 32'h1);
        wr(WDC_CTRL_OFF, 32'h08);
        repeat (10) begin
            wr(WDC_KICK_OFF, 32'h1);
            repeat (30) @(posedge hclk);
        end
        chk_val(pulse_cnt, p0); // kick restarts
        // every select code, with the interrupt raised and cleared
        for (int s = 0; s < 8; s++) begin
            wr(WDC_CTRL_OFF, 32'h18);
            wr(WDC_CTRL_OFF, 32'h08 | s);
            wr(WDC_KICK_OFF, 32'h1);
            lo = 37 * (BASE << s) / 10 - 10;
            wait_pulse(9000, n);
            chk_cnt(n, lo, lo + 50); // timeout length
            repeat (3) @(posedge hclk);
            chk_val({31'h0, irq}, 32'h1); // expiry raises irq
            rchk(WDC_IRQ_STAT_OFF, 32'h1);
            wr(WDC_IRQ_STAT_OFF, 32'h1);
            repeat (2) @(posedge hclk);
            chk_val({31'h0, irq}, 32'h0);
        end
        // safety level two, expiry masked out of irq
        wr(WDC_IRQ_MASK_OFF, 32'h0);
        hresetn <= 1'b0;
        safety_fuse <= 1'b1;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        // let the enable crossing settle so the busy bit reads clear
        repeat (30) @(posedge hclk);
        rchk(WDC_CTRL_OFF, 32'h08); // reads enabled
        rchk(WDC_STATUS_OFF, 32'h3); // running on fuse
        wr(WDC_CTRL_OFF, 32'h18);
        wr(WDC_CTRL_OFF, 32'h00);
        wr(WDC_KICK_OFF, 32'h1);
        rchk(WDC_CTRL_OFF, 32'h08); // cannot disable
        rchk(WDC_IRQ_STAT_OFF, 32'h2); // refusal flagged
        wait_pulse(400, n);
        chk_cnt(n, 1, 120); // still expires
        repeat (3) @(posedge hclk);
        chk_val({31'h0, irq}, 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
